//--- quad_sw_pkg.sv
// constants, types and helpers shared by the quad switch control logic
package quad_sw_pkg;

    // frame layout
    localparam int          CH_N     = 4;
    localparam int          BYTE_W   = 8;
    localparam int          NIB_W    = 4;
    localparam int          IDX_W    = 3;
    localparam int          CODE_W   = 2;
    localparam logic [2:0]  IDX_LAST = 3'h7;

    // control nibbles
    localparam logic [3:0]  CMD_DIAG = 4'h0;
    localparam logic [3:0]  CMD_READ = 4'hc;
    localparam logic [3:0]  CMD_ECHO = 4'ha;
    localparam logic [3:0]  CMD_OR   = 4'h3;
    localparam logic [3:0]  CMD_AND  = 4'hf;

    // two-bit channel status codes
    localparam logic [1:0]  DG_OK    = 2'h3;
    localparam logic [1:0]  DG_LIMIT = 2'h2;
    localparam logic [1:0]  DG_OPEN  = 2'h1;
    localparam logic [1:0]  DG_SHORT = 2'h0;

    // bit positions of the synchronised pin vector
    localparam int          PIN_W    = 23;
    localparam int          PIN_CS   = 22;
    localparam int          PIN_SI   = 21;
    localparam int          PIN_RSTN = 20;
    localparam int          PIN_PRG  = 19;
    localparam int          PIN_GRAY = 16;
    localparam int          PIN_IN   = 12;
    localparam int          PIN_LIM  = 8;
    localparam int          PIN_OPEN = 4;
    localparam int          PIN_GND  = 0;
    // idle levels: chip select, reset pin and program pin high
    localparam logic [22:0] PIN_RST  = 23'h580000;

    typedef enum logic {OP_OR, OP_AND} bool_op_t;
    typedef enum logic [1:0] {TX_FULL, TX_READ, TX_ECHO} tx_sel_t;

    function automatic logic [2:0] bin2gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [2:0] gray2bin(input logic [2:0] g);
        return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction

endpackage

//--- link_if.sv
// carrier between the serial-clock logic and the core logic
interface link_if;
    logic [7:0] rx_byte;
    logic [2:0] tx_gray;
    modport link (output rx_byte, output tx_gray);
    modport core (input rx_byte, input tx_gray);
endinterface

//--- spi_link.sv
// serial-clock domain: receive shift register and output bit index
module spi_link (
    input  wire logic sclk_i,
    input  wire logic rst_i,
    input  wire logic reset_n_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    link_if.link      lk
);

    logic       rx_clr;
    logic       tx_clr;
    logic [7:0] rx_r;
    logic [2:0] gray_r;

    // reset pin clears the shift register without any clock edge
    assign rx_clr = rst_i | ~reset_n_i;
    // the index dies with the frame, since sclk may stop after it
    assign tx_clr = rx_clr | cs_n_i;

    // sample on falling edge, msb first; ignored while deselected
    always_ff @(negedge sclk_i or posedge rx_clr) begin
        if (rx_clr) begin
            rx_r <= '0;
        end else if (!cs_n_i) begin
            rx_r <= {rx_r[6:0], si_i};
        end
    end

    // advance output index on rising edge, gray coded for the crossing
    always_ff @(posedge sclk_i or posedge tx_clr) begin
        if (tx_clr) begin
            gray_r <= '0;
        end else if (quad_sw_pkg::gray2bin(gray_r) != quad_sw_pkg::IDX_LAST) begin
            gray_r <= quad_sw_pkg::bin2gray(quad_sw_pkg::gray2bin(gray_r) + 3'h1);
        end
    end

    // rx byte is static once chip select is high, so it is read as is
    assign lk.rx_byte = rx_r;
    assign lk.tx_gray = gray_r;

endmodule

//--- quad_switch_ctrl.sv
// control logic of a serially driven quad low-side switch
module quad_switch_ctrl (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    input  wire logic       reset_n_i,
    input  wire logic       prg_i,
    input  wire logic [3:0] parallel_channel_inputs_i,
    input  wire logic [3:0] short_to_supply_i,
    input  wire logic [3:0] open_load_i,
    input  wire logic [3:0] short_gnd_i,
    output logic      [3:0] channel_on_o,
    output logic            so_o,
    output logic            so_oe_o,
    output logic            fault_o,
    output logic            fault_oe_o,
    output logic            op_and_o
);

    // link side in its own clock domain
    link_if lk ();

    spi_link u_link (
        .sclk_i    (sclk_i),
        .rst_i     (rst_i),
        .reset_n_i (reset_n_i),
        .cs_n_i    (cs_n_i),
        .si_i      (si_i),
        .lk        (lk)
    );

    // pin synchronisers

    logic [quad_sw_pkg::PIN_W-1:0] pin_raw;
    logic [quad_sw_pkg::PIN_W-1:0] s1_r;
    logic [quad_sw_pkg::PIN_W-1:0] s2_r;
    logic [quad_sw_pkg::PIN_W-1:0] s3_r;
    logic [quad_sw_pkg::PIN_W-1:0] pin_r;

    // every asynchronous input gathered into one vector
    assign pin_raw = {
        cs_n_i,
        si_i,
        reset_n_i,
        prg_i,
        lk.tx_gray,
        parallel_channel_inputs_i,
        short_to_supply_i,
        open_load_i,
        short_gnd_i
    };

    // three stages; a change counts once stages two and three agree
    for (genvar gi = 0; gi < quad_sw_pkg::PIN_W; gi++) begin : g_sync
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                s1_r[gi]  <= quad_sw_pkg::PIN_RST[gi];
                s2_r[gi]  <= quad_sw_pkg::PIN_RST[gi];
                s3_r[gi]  <= quad_sw_pkg::PIN_RST[gi];
                pin_r[gi] <= quad_sw_pkg::PIN_RST[gi];
            end else begin
                s1_r[gi] <= pin_raw[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    pin_r[gi] <= s3_r[gi];
                end
            end
        end
    end

    // unpacked pin levels

    logic       cs_n_q;
    logic       si_q;
    logic       rstn_q;
    logic       prg_q;
    logic [2:0] gray_q;
    logic [3:0] in_q;
    logic [3:0] lim_q;
    logic [3:0] open_q;
    logic [3:0] gnd_q;

    assign cs_n_q = pin_r[quad_sw_pkg::PIN_CS];
    assign si_q   = pin_r[quad_sw_pkg::PIN_SI];
    assign rstn_q = pin_r[quad_sw_pkg::PIN_RSTN];
    assign prg_q  = pin_r[quad_sw_pkg::PIN_PRG];
    assign gray_q = pin_r[quad_sw_pkg::PIN_GRAY +: quad_sw_pkg::IDX_W];
    assign in_q   = pin_r[quad_sw_pkg::PIN_IN +: quad_sw_pkg::CH_N];
    assign lim_q  = pin_r[quad_sw_pkg::PIN_LIM +: quad_sw_pkg::CH_N];
    assign open_q = pin_r[quad_sw_pkg::PIN_OPEN +: quad_sw_pkg::CH_N];
    assign gnd_q  = pin_r[quad_sw_pkg::PIN_GND +: quad_sw_pkg::CH_N];

    // frame edges and decoded command

    logic       cs_prev_r;
    logic       cs_rise;
    logic       pin_rst;
    logic [3:0] eff_in;
    logic [3:0] cmd;
    logic [3:0] dat;
    logic       is_data_cmd;
    logic [2:0] so_idx;

    // previous chip select level for edge detection
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_prev_r <= 1'b1;
        end else begin
            cs_prev_r <= cs_n_q;
        end
    end

    // frame ends when chip select returns high
    assign cs_rise = ~cs_prev_r & cs_n_q;
    assign pin_rst = ~rstn_q;

    // program pin picks high or low active parallel inputs
    assign eff_in = prg_q ? in_q : ~in_q;

    // shift register is idle after the frame, so it is read directly
    assign cmd = lk.rx_byte[quad_sw_pkg::BYTE_W-1 -: quad_sw_pkg::NIB_W];
    assign dat = lk.rx_byte[quad_sw_pkg::NIB_W-1:0];

    // everything but the three special nibbles carries channel bits
    assign is_data_cmd = (cmd != quad_sw_pkg::CMD_DIAG) &&
                         (cmd != quad_sw_pkg::CMD_READ) &&
                         (cmd != quad_sw_pkg::CMD_ECHO);

    assign so_idx = quad_sw_pkg::gray2bin(gray_q);

    // boolean operation and channel bits

    quad_sw_pkg::bool_op_t op_r;
    logic [3:0]            serial_channel_bits_r;

    // retained combination; only the two explicit nibbles and the reset pin change it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_r <= quad_sw_pkg::OP_OR;
        end else if (pin_rst) begin
            op_r <= quad_sw_pkg::OP_OR;
        end else if (cs_rise) begin
            if (cmd == quad_sw_pkg::CMD_OR) begin
                op_r <= quad_sw_pkg::OP_OR;
            end else if (cmd == quad_sw_pkg::CMD_AND) begin
                op_r <= quad_sw_pkg::OP_AND;
            end
        end
    end

    // zero bits at reset make the or case pass parallel inputs through
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_channel_bits_r <= '0;
        end else if (pin_rst) begin
            serial_channel_bits_r <= '0;
        end else if (cs_rise && is_data_cmd) begin
            serial_channel_bits_r <= dat;
        end
    end

    // what the next frame sends back

    quad_sw_pkg::tx_sel_t tx_sel_r;

    // read-back and echo last one frame; all else gives full diagnosis
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sel_r <= quad_sw_pkg::TX_FULL;
        end else if (cs_rise) begin
            case (cmd)
                quad_sw_pkg::CMD_READ: begin
                    tx_sel_r <= quad_sw_pkg::TX_READ;
                end
                quad_sw_pkg::CMD_ECHO: begin
                    tx_sel_r <= quad_sw_pkg::TX_ECHO;
                end
                default: begin
                    tx_sel_r <= quad_sw_pkg::TX_FULL;
                end
            endcase
        end
    end

    // per-channel diagnosis

    logic [7:0] code_now;
    logic [7:0] diag_r;
    logic [3:0] ch_ok;
    logic [3:0] ch_err;

    for (genvar gc = 0; gc < quad_sw_pkg::CH_N; gc++) begin : g_diag
        // current limit outranks the ground short, which outranks open load
        always_comb begin
            if (lim_q[gc]) begin
                code_now[gc*2 +: 2] = quad_sw_pkg::DG_LIMIT;
            end else if (gnd_q[gc]) begin
                code_now[gc*2 +: 2] = quad_sw_pkg::DG_SHORT;
            end else if (open_q[gc]) begin
                code_now[gc*2 +: 2] = quad_sw_pkg::DG_OPEN;
            end else begin
                code_now[gc*2 +: 2] = quad_sw_pkg::DG_OK;
            end
        end

        assign ch_err[gc] = code_now[gc*2 +: 2] != quad_sw_pkg::DG_OK;

        // a live fault beats the clear, so no event is lost at the edge
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                diag_r[gc*2 +: 2] <= quad_sw_pkg::DG_OK;
            end else if (ch_err[gc]) begin
                diag_r[gc*2 +: 2] <= code_now[gc*2 +: 2];
            end else if (cs_rise || pin_rst) begin
                diag_r[gc*2 +: 2] <= quad_sw_pkg::DG_OK;
            end
        end

        // one-bit summary for the read-back byte
        assign ch_ok[gc] = diag_r[gc*2 +: 2] == quad_sw_pkg::DG_OK;
    end

    // serial output

    logic [7:0] snap_r;
    logic       so_r;
    logic       so_oe_r;

    // follows the live word while idle, frozen for the whole frame
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            snap_r <= {quad_sw_pkg::CH_N{quad_sw_pkg::DG_OK}};
        end else if (cs_n_q) begin
            if (tx_sel_r == quad_sw_pkg::TX_READ) begin
                snap_r <= {eff_in, ch_ok};
            end else begin
                snap_r <= diag_r;
            end
        end
    end

    // index crosses as gray code, so a torn read is one step off at most
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            so_r <= 1'b0;
        end else if (cs_n_q) begin
            so_r <= 1'b0;
        end else if (tx_sel_r == quad_sw_pkg::TX_ECHO) begin
            so_r <= si_q;
        end else begin
            so_r <= snap_r[quad_sw_pkg::IDX_LAST - so_idx];
        end
    end

    // driver enabled only inside a frame
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= ~cs_n_q;
        end
    end

    assign so_o    = so_r;
    assign so_oe_o = so_oe_r;

    // channel drive

    logic [3:0] out_r;

    // outputs forced off for as long as the reset pin is low
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_r <= '0;
        end else if (pin_rst) begin
            out_r <= '0;
        end else if (op_r == quad_sw_pkg::OP_OR) begin
            out_r <= eff_in | serial_channel_bits_r;
        end else begin
            out_r <= eff_in & serial_channel_bits_r;
        end
    end

    assign channel_on_o = out_r;

    // fault flag and status

    logic fault_oe_r;
    logic fault_lvl_r;
    logic op_and_r;

    // pulls low on a live error or one still latched
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_oe_r <= 1'b0;
        end else begin
            fault_oe_r <= (|ch_err) || !(&ch_ok);
        end
    end

    // open drain: the driven level is always low
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_lvl_r <= 1'b0;
        end else begin
            fault_lvl_r <= 1'b0;
        end
    end

    // reports the retained combination
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_and_r <= 1'b0;
        end else begin
            op_and_r <= op_r == quad_sw_pkg::OP_AND;
        end
    end

    assign fault_o    = fault_lvl_r;
    assign fault_oe_o = fault_oe_r;
    assign op_and_o   = op_and_r;

endmodule

//--- quad_switch_ctrl_properties.sv
// concurrent checks on the quad switch control logic ports
module quad_switch_ctrl_properties (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n_i,
    input  wire logic       reset_n_i,
    input  wire logic       prg_i,
    input  wire logic [3:0] parallel_channel_inputs_i,
    input  wire logic [3:0] short_to_supply_i,
    input  wire logic [3:0] open_load_i,
    input  wire logic [3:0] short_gnd_i,
    input  wire logic [3:0] channel_on_o,
    input  wire logic       so_oe_o,
    input  wire logic       fault_oe_o,
    input  wire logic       op_and_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_cs_hiz;
        cs_n_i [*6] |-> !so_oe_o;
    endproperty
    a_cs_hiz: assert property (p_cs_hiz)
        else $error("serial out driven while deselected");

    property p_cs_drive;
        !cs_n_i [*6] |-> so_oe_o;
    endproperty
    a_cs_drive: assert property (p_cs_drive)
        else $error("serial out not driven while selected");

    property p_reset_off;
        !reset_n_i [*6] |-> channel_on_o == 4'h0;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("channel on while reset pin low");

    // op register sits one stage behind the channel drive, so one cycle more
    property p_reset_or;
        !reset_n_i [*7] |-> !op_and_o;
    endproperty
    a_reset_or: assert property (p_reset_or)
        else $error("and kept while reset pin low");

    // detector rise must reach the flag within the sync latency
    property p_fault_fast;
        $rose(|(short_to_supply_i | open_load_i | short_gnd_i)) |-> ##[1:8] fault_oe_o;
    endproperty
    a_fault_fast: assert property (p_fault_fast)
        else $error("fault flag late after detector rise");

    // latched faults only leave at a chip select rise or while the reset pin is low
    property p_fault_clear;
        $fell(fault_oe_o) && reset_n_i |-> !$past(cs_n_i, 7);
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag released outside a frame end");

    property p_op_set;
        $rose(op_and_o) |-> !$past(cs_n_i, 7);
    endproperty
    a_op_set: assert property (p_op_set)
        else $error("and selected without a frame");

    property p_op_clr;
        $fell(op_and_o) && reset_n_i |-> !$past(cs_n_i, 7);
    endproperty
    a_op_clr: assert property (p_op_clr)
        else $error("or selected without a frame");

    // outputs move only on frame ends, reset pin, program pin or parallel inputs
    property p_chan_stable;
        $stable({parallel_channel_inputs_i, prg_i, cs_n_i, reset_n_i}) [*8]
            |-> $stable(channel_on_o);
    endproperty
    a_chan_stable: assert property (p_chan_stable)
        else $error("channel drive changed without cause");
endmodule

bind quad_switch_ctrl quad_switch_ctrl_properties props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .reset_n_i(reset_n_i),
    .prg_i(prg_i), .parallel_channel_inputs_i(parallel_channel_inputs_i),
    .short_to_supply_i(short_to_supply_i), .open_load_i(open_load_i),
    .short_gnd_i(short_gnd_i), .channel_on_o(channel_on_o), .so_oe_o(so_oe_o),
    .fault_oe_o(fault_oe_o), .op_and_o(op_and_o)
);

//--- spi_master_model.sv
// serial master model: one byte per chip select period
module spi_master_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // serial clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // data changes after falling edge, captured before rising edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7;
        cs_n_o = 1'b0;
        // 80 ns per bit; si settles well before the capture for echo frames
        for (int i = 7; i >= 0; i--) begin
            #5 si_o = tx[i];
            #60 rx[i] = so_oe_i ? so_i : 1'bx;
            sclk_o = 1'b1;
            #15 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        si_o = ~si_o; // a released line keeps no stale level
    endtask
endmodule

//--- tb_quad_switch_ctrl.sv
// self-checking bench of the quad switch control logic
module tb_quad_switch_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic       ref_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       reset_n   = 1'b1;
    logic       prg       = 1'b1;
    logic [3:0] par_in    = 4'h0;
    logic [3:0] lim_in    = 4'h0;
    logic [3:0] open_in   = 4'h0;
    logic [3:0] gnd_in    = 4'h0;
    logic       sclk, cs_n, si, so, so_oe, fault, fault_oe, op_and;
    logic [3:0] chan;
    logic [7:0] rx;
    int         fails     = 0;
    int         n_tests   = 0;
    // command sequence: or, other, and, other, diag, read-back, echo, or
    logic [7:0] cmds [8]  = '{{quad_sw_pkg::CMD_OR, 4'h9}, 8'h74,
        {quad_sw_pkg::CMD_AND, 4'h6}, 8'h9f, {quad_sw_pkg::CMD_DIAG, 4'h0},
        {quad_sw_pkg::CMD_READ, 4'h0}, {quad_sw_pkg::CMD_ECHO, 4'h0},
        {quad_sw_pkg::CMD_OR, 4'h0}};
    logic [3:0] pins  [8] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1};
    logic [3:0] chans [8] = '{4'hb, 4'h6, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1};
    logic       ops   [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] rxs   [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h30};
    logic [7:0] bad;

    always #5 ref_clk_i = ~ref_clk_i;

    quad_switch_ctrl dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
        .reset_n_i(reset_n), .prg_i(prg), .parallel_channel_inputs_i(par_in),
        .short_to_supply_i(lim_in), .open_load_i(open_in), .short_gnd_i(gnd_in),
        .channel_on_o(chan), .so_o(so), .so_oe_o(so_oe), .fault_o(fault),
        .fault_oe_o(fault_oe), .op_and_o(op_and)
    );

    spi_master_model master (
        .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe)
    );

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // pins pass four sync flops, so allow a dozen cycles
    task automatic settle();
        repeat (12) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic send(input logic [7:0] tx);
        master.xfer(tx, rx);
        settle();
    endtask

    task automatic set_in(input logic [3:0] p, input logic [3:0] l,
                          input logic [3:0] o, input logic [3:0] g);
        @(posedge ref_clk_i);
        #1;
        par_in  = p;
        lim_in  = l;
        open_in = o;
        gnd_in  = g;
        settle();
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the single long settle wait
    initial begin
        #600us;
        fails++;
        finish_test();
    end

    initial begin
        bad = {quad_sw_pkg::DG_LIMIT, quad_sw_pkg::DG_OK, quad_sw_pkg::DG_OPEN,
               quad_sw_pkg::DG_SHORT};
        repeat (10) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        settle();
        set_in(4'h5, 4'h0, 4'h0, 4'h0);
        cmp("op", 8'h00, {7'h0, op_and});
        cmp("chan", 8'h05, {4'h0, chan});
        cmp("so_oe", 8'h00, {7'h0, so_oe});
        prg = 1'b0;
        settle();
        cmp("chan", 8'h0a, {4'h0, chan});
        prg = 1'b1;
        // command table, each frame also reads the previous selection
        for (int i = 0; i < 8; i++) begin
            set_in(pins[i], 4'h0, 4'h0, 4'h0);
            send(cmds[i]);
            cmp("rx", rxs[i], rx);
            cmp("chan", {4'h0, chans[i]}, {4'h0, chan});
            cmp("op", {7'h0, ops[i]}, {7'h0, op_and});
        end
        // faults: limit on 4, open on 2, short on 1, channel 3 healthy
        set_in(4'h0, 4'h8, 4'h2, 4'h1);
        cmp("fault_oe", 8'h01, {7'h0, fault_oe});
        cmp("fault", 8'h00, {7'h0, fault});
        send(8'h00);
        cmp("rx", bad, rx);
        #150us;
        send(8'h00);
        cmp("rx", bad, rx);
        set_in(4'h0, 4'h0, 4'h0, 4'h0);
        cmp("fault_oe", 8'h01, {7'h0, fault_oe});
        send(8'h00);
        cmp("rx", bad, rx);
        cmp("fault_oe", 8'h00, {7'h0, fault_oe});
        send(8'h00);
        cmp("rx", 8'hff, rx);
        // a later open load replaces an earlier limit report
        set_in(4'h0, 4'h4, 4'h0, 4'h0);
        set_in(4'h0, 4'h0, 4'h0, 4'h0);
        set_in(4'h0, 4'h0, 4'h4, 4'h0);
        set_in(4'h0, 4'h0, 4'h0, 4'h0);
        send(8'h00);
        cmp("rx", 8'hdf, rx);
        // reset pin drops and selection
        set_in(4'h6, 4'h0, 4'h0, 4'h0);
        send({quad_sw_pkg::CMD_AND, 4'hf});
        cmp("op", 8'h01, {7'h0, op_and});
        reset_n = 1'b0;
        settle();
        cmp("chan", 8'h00, {4'h0, chan});
        cmp("op", 8'h00, {7'h0, op_and});
        reset_n = 1'b1;
        settle();
        cmp("chan", 8'h06, {4'h0, chan});
        finish_test();
    end
endmodule
